// >>> verilog/tdic_cfg.svh
`ifndef TDIC_CFG_SVH
`define TDIC_CFG_SVH

// clock and link rate
`define TDIC_CLK_HZ        40000000
`define TDIC_BUS_BPS       375000
`define TDIC_BIT_CYC       (`TDIC_CLK_HZ / `TDIC_BUS_BPS)

// per-channel sampling schedule
`define TDIC_SAMPLE_US     1000
`define TDIC_SAMPLE_CYC    (`TDIC_SAMPLE_US * (`TDIC_CLK_HZ / 1000000))

// self-test interval, must stay below the detection limit
`define TDIC_TEST_LIMIT_MS 500
`define TDIC_TEST_MS       100
`define TDIC_TEST_CYC      (`TDIC_TEST_MS * (`TDIC_CLK_HZ / 1000))

// settling time of the isolation stage after a test switch moves
`define TDIC_SETTLE_US     10
`define TDIC_SETTLE_CYC    (`TDIC_SETTLE_US * (`TDIC_CLK_HZ / 1000000))

// frame markers on a bus leg
`define TDIC_START_BIT     1'h0
`define TDIC_STOP_BIT      1'h1

// reset value and channel count
`define TDIC_TX_IDLE       1'h1
`define TDIC_NUM_CH        3

`endif

// >>> verilog/tdic_pkg.sv
package tdic_pkg;

  // self-test sequencer of one channel
  typedef enum logic [1:0] {
    TDIC_ST_RUN   = 2'b00,
    TDIC_ST_ZERO  = 2'b01,
    TDIC_ST_ONE   = 2'b10
  } tdic_state_t;

endpackage

// >>> verilog/tdic_top.sv
`timescale 1ns/1ps
`include "tdic_cfg.svh"

// Contract
// - three identical channels, each with its own link logic, no shared state
// - each channel samples every point on its own schedule into its table
// - channel n answers only polls arriving on bus leg n
// - stuck-ON test closes a switch forcing zero; a point reading ON is faulty
// - during a self-test the reported table stays frozen at its last reading
// - a faulted point is always reported OFF
// - single variant checks stuck-ON and stuck-OFF within half a second
// - each bus leg runs at 375 kilobits per second
module tdic_top #(
  parameter int unsigned NPTS       = 16,
  parameter bit          SINGLE     = 1'b0,
  parameter int unsigned SAMPLE_CYC = `TDIC_SAMPLE_CYC,
  parameter int unsigned TEST_CYC   = `TDIC_TEST_CYC
) (
  input  wire logic                             clock,
  input  wire logic                             resetn,
  input  wire logic [`TDIC_NUM_CH*NPTS-1:0]     field_in,
  input  wire logic [`TDIC_NUM_CH-1:0]          leg_rx,
  output logic      [`TDIC_NUM_CH-1:0]          leg_tx,
  output logic      [`TDIC_NUM_CH-1:0]          force_zero,
  output logic      [`TDIC_NUM_CH-1:0]          force_one
);
  import tdic_pkg::*;

  localparam int unsigned BIT_CYC    = `TDIC_BIT_CYC;
  localparam int unsigned SETTLE_CYC = `TDIC_SETTLE_CYC;
  localparam int unsigned FRAME      = 2 * NPTS + 2;
  localparam int unsigned BCW        = $clog2(FRAME + 1);

  // set for each point that reads the value a forced test should have hidden
  function automatic logic [NPTS-1:0] bad_points(input logic [NPTS-1:0] rd,
                                                 input logic            want);
    bad_points = want ? ~rd : rd;
  endfunction

  genvar ch;
  generate
    for (ch = 0; ch < `TDIC_NUM_CH; ch = ch + 1) begin : g_ch
      logic [NPTS-1:0]  fld_s1_q;
      logic [NPTS-1:0]  fld_s2_q;
      logic             rx_s1_q;
      logic             rx_s2_q;
      logic             rx_d1_q;
      logic [31:0]      smp_cnt_q;
      logic [31:0]      tst_cnt_q;
      logic [31:0]      stl_cnt_q;
      tdic_state_t      st_q;
      tdic_state_t      st_d;
      logic [NPTS-1:0]  table_q;
      logic [NPTS-1:0]  flt_q;
      logic [NPTS-1:0]  flt_new_q;
      logic [NPTS-1:0]  rpt_q;
      logic [NPTS-1:0]  sent_q;
      logic [FRAME-1:0] sh_q;
      logic [BCW-1:0]   bits_q;
      logic [31:0]      baud_q;
      logic             busy_q;
      logic             tx_q;
      logic             zero_q;
      logic             one_q;

      wire              smp_tick   = (smp_cnt_q == 32'h0000_0000);
      wire              tst_tick   = (tst_cnt_q == 32'h0000_0000);
      wire              settled    = (stl_cnt_q == 32'h0000_0000);
      // stays frozen while the isolation stage settles back, so no forced reading lands
      wire              testing    = (st_q != TDIC_ST_RUN) || !settled;
      wire              chk_zero   = (st_q == TDIC_ST_ZERO) && settled;
      wire              chk_one    = (st_q == TDIC_ST_ONE) && settled;
      wire [NPTS-1:0]   stuck_on   = chk_zero ? bad_points(fld_s2_q, 1'b0) : '0;
      wire [NPTS-1:0]   stuck_off  = chk_one ? bad_points(fld_s2_q, 1'b1) : '0;
      wire [NPTS-1:0]   flt_set    = stuck_on | stuck_off;
      wire              test_done  = SINGLE ? chk_one : chk_zero;
      wire              baud_tick  = (baud_q == 32'h0000_0000);
      wire              poll       = rx_d1_q && !rx_s2_q && !busy_q;
      wire              last_bit   = busy_q && baud_tick && (bits_q == BCW'(1));
      // faulted points go out as OFF
      wire [NPTS-1:0]   report     = table_q & ~flt_q;
      // only flags that went out are cleared; later detections wait for the next poll
      wire [NPTS-1:0]   rpt_clr    = last_bit ? sent_q : '0;

      // two flops on everything coming from the field or the bus leg
      always_ff @(posedge clock) begin
        fld_s1_q <= field_in[ch*NPTS +: NPTS];
        fld_s2_q <= fld_s1_q;
        rx_s1_q  <= leg_rx[ch];
        rx_s2_q  <= rx_s1_q;
      end

      always_ff @(posedge clock) begin
        if (!resetn) begin
          rx_d1_q <= 1'h1;
        end else begin
          rx_d1_q <= rx_s2_q;
        end
      end

      // own schedule, phase staggered per channel
      always_ff @(posedge clock) begin
        if (!resetn) begin
          smp_cnt_q <= 32'((SAMPLE_CYC / 3) * ch);
        end else if (smp_tick) begin
          smp_cnt_q <= 32'(SAMPLE_CYC - 1);
        end else begin
          smp_cnt_q <= smp_cnt_q - 32'h0000_0001;
        end
      end

      always_ff @(posedge clock) begin
        if (!resetn) begin
          table_q <= '0;
        end else if (smp_tick && !testing) begin
          table_q <= fld_s2_q;
        end
      end

      // test interval below the detection limit
      always_ff @(posedge clock) begin
        if (!resetn) begin
          tst_cnt_q <= 32'(TEST_CYC - 1);
        end else if (tst_tick) begin
          tst_cnt_q <= 32'(TEST_CYC - 1);
        end else begin
          tst_cnt_q <= tst_cnt_q - 32'h0000_0001;
        end
      end

      always_comb begin
        st_d = st_q;
        case (st_q)
          TDIC_ST_RUN: begin
            if (tst_tick) begin
              st_d = TDIC_ST_ZERO;
            end
          end
          TDIC_ST_ZERO: begin
            if (settled) begin
              st_d = SINGLE ? TDIC_ST_ONE : TDIC_ST_RUN;
            end
          end
          TDIC_ST_ONE: begin
            if (settled) begin
              st_d = TDIC_ST_RUN;
            end
          end
          default: begin
            st_d = TDIC_ST_RUN;
          end
        endcase
      end

      always_ff @(posedge clock) begin
        if (!resetn) begin
          st_q      <= TDIC_ST_RUN;
          stl_cnt_q <= 32'h0000_0000;
        end else begin
          st_q <= st_d;
          if (st_d != st_q) begin
            stl_cnt_q <= 32'(SETTLE_CYC - 1);
          end else if (!settled) begin
            stl_cnt_q <= stl_cnt_q - 32'h0000_0001;
          end
        end
      end

      always_ff @(posedge clock) begin
        if (!resetn) begin
          zero_q <= 1'h0;
          one_q  <= 1'h0;
        end else begin
          zero_q <= (st_d == TDIC_ST_ZERO);
          one_q  <= (st_d == TDIC_ST_ONE);
        end
      end

      // a point's fault stays until a whole later test passes it
      always_ff @(posedge clock) begin
        if (!resetn) begin
          flt_q     <= '0;
          flt_new_q <= '0;
        end else if (test_done) begin
          flt_q     <= flt_new_q | flt_set;
          flt_new_q <= '0;
        end else begin
          flt_q     <= flt_q | flt_set;
          flt_new_q <= flt_new_q | flt_set;
        end
      end

      // sticky report flag, a new detection beats the clear
      always_ff @(posedge clock) begin
        if (!resetn) begin
          rpt_q <= '0;
        end else begin
          rpt_q <= (rpt_q & ~rpt_clr) | flt_set;
        end
      end

      // bit time from the leg rate
      always_ff @(posedge clock) begin
        if (!resetn) begin
          busy_q <= 1'h0;
          sent_q <= '0;
          sh_q   <= '1;
          bits_q <= '0;
          baud_q <= 32'h0000_0000;
          tx_q   <= `TDIC_TX_IDLE;
        end else if (poll) begin
          busy_q <= 1'h1;
          sent_q <= rpt_q;
          sh_q   <= {`TDIC_STOP_BIT, rpt_q, report, `TDIC_START_BIT};
          bits_q <= BCW'(FRAME);
          baud_q <= 32'(BIT_CYC - 1);
          tx_q   <= `TDIC_START_BIT;
        end else if (busy_q && baud_tick) begin
          busy_q <= !last_bit;
          sh_q   <= {1'h1, sh_q[FRAME-1:1]};
          bits_q <= bits_q - BCW'(1);
          baud_q <= 32'(BIT_CYC - 1);
          tx_q   <= last_bit ? `TDIC_TX_IDLE : sh_q[1];
        end else if (busy_q) begin
          baud_q <= baud_q - 32'h0000_0001;
        end
      end

      assign leg_tx[ch]     = tx_q;
      assign force_zero[ch] = zero_q;
      assign force_one[ch]  = one_q;
    end
  endgenerate

endmodule

// >>> testbench/tdic_top_monitor.sv
`timescale 1ns/1ps
`include "tdic_cfg.svh"
module tdic_chk #(
  parameter int unsigned NPTS   = 16,
  parameter bit          SINGLE = 1'b0
) (
  input wire logic              clock,
  input wire logic              resetn,
  input wire logic [3*NPTS-1:0] field_in,
  input wire logic [2:0]        leg_rx,
  input wire logic [2:0]        leg_tx,
  input wire logic [2:0]        force_zero,
  input wire logic [2:0]        force_one
);
  localparam int BIT = `TDIC_BIT_CYC;
  localparam int FR  = (2*NPTS+2)*BIT;
  int          fc_q [3];
  logic [2:0]  tx_q;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // sample index within a reply frame, 0 when the leg is idle
  always_ff @(posedge clock) begin
    tx_q <= leg_tx;
    for (int i = 0; i < 3; i++) begin
      if (!resetn) fc_q[i] <= 0;
      else if (fc_q[i] != 0) fc_q[i] <= (fc_q[i] == FR-1) ? 0 : fc_q[i] + 1;
      else if (tx_q[i] && !leg_tx[i]) fc_q[i] <= 1;
    end
  end
  for (genvar i = 0; i < 3; i++) begin : g_ch
    a_poll_reply: assert property ($fell(leg_rx[i]) && fc_q[i] == 0 |-> ##[3:5] !leg_tx[i])
      else $error("poll not answered");
    a_no_unpolled: assert property ($fell(leg_tx[i]) && fc_q[i] == 0 |->
      !$past(leg_rx[i], 3) || !$past(leg_rx[i], 4) || !$past(leg_rx[i], 5))
      else $error("reply without poll");
    a_start_len: assert property (fc_q[i] != 0 && fc_q[i] < BIT |-> !leg_tx[i])
      else $error("start bit short");
    a_stop_high: assert property (fc_q[i] >= FR-BIT |-> leg_tx[i])
      else $error("stop bit low");
    a_force_len: assert property ($fell(force_zero[i]) |->
      $past(force_zero[i], 400) && !$past(force_zero[i], 401))
      else $error("test phase length");
    a_force_excl: assert property (!(force_zero[i] && force_one[i]))
      else $error("both test switches");
    a_one_single: assert property (force_one[i] |-> SINGLE)
      else $error("force one on triple variant");
    a_one_len: assert property ($fell(force_one[i]) |->
      $past(force_one[i], 400) && !$past(force_one[i], 401))
      else $error("stuck-off phase length");
  end
  a_reset_idle: assert property (disable iff (1'b0) !resetn |=>
    &leg_tx && force_zero == 3'h0 && force_one == 3'h0)
    else $error("outputs not idle after reset");
  c_test: cover property ($rose(force_zero[0]));
  c_frame: cover property (fc_q[1] == FR-1);
  c_poll: cover property ($fell(leg_rx[2]));
  c_one: cover property ($rose(force_one[0]));
endmodule
bind tdic_top tdic_chk #(.NPTS(NPTS), .SINGLE(SINGLE)) u_chk (.clock, .resetn, .field_in,
  .leg_rx, .leg_tx, .force_zero, .force_one);

// >>> testbench/tdic_mp.sv
`timescale 1ns/1ps
module tdic_mp #(
  parameter int unsigned NPTS = 16,
  parameter int unsigned BIT  = 106
) (
  input  wire logic clock,
  input  wire logic leg_tx,
  output logic      leg_rx
);
  initial leg_rx = 1'h1;
  // one-cycle poll, then mid-bit sampling of the frame
  task automatic poll(output logic [2*NPTS-1:0] d, output logic ok);
    int n;
    n = 0;
    @(posedge clock) leg_rx <= 1'h0;
    @(posedge clock) leg_rx <= 1'h1;
    while (leg_tx && n < 20) begin
      @(negedge clock);
      n++;
    end
    repeat (BIT/2) @(negedge clock);
    ok = !leg_tx;
    for (int k = 0; k <= 2*NPTS; k++) begin
      repeat (BIT) @(negedge clock);
      if (k < 2*NPTS) d[k] = leg_tx;
    end
    ok = ok && leg_tx;
    // a poll before the stop bit ends would be ignored
    repeat (BIT/2 + 2) @(negedge clock);
  endtask
endmodule

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
`include "tdic_cfg.svh"
module tb_top;
  localparam int N = 16;
  logic           clock;
  logic           resetn;
  logic [3*N-1:0] field_in;
  wire  [2:0]     leg_rx;
  logic [2:0]     leg_tx;
  logic [2:0]     force_zero;
  logic [2:0]     force_one;
  logic [N-1:0]   pat [3];
  logic [N-1:0]   stuck [3];
  logic [2*N-1:0] d0, d1, d2;
  logic           ok0, ok1, ok2;
  logic [N-1:0]   soff [3];
  logic [3*N-1:0] fs_in;
  logic [2:0]     tx_s;
  logic [2:0]     fz_s;
  logic [2:0]     fo_s;
  wire            rx_s;
  logic [2*N-1:0] ds;
  logic           oks;
  int             bad_count;
  int             num_checks;
  tdic_top #(.NPTS(N), .SINGLE(1'b0), .SAMPLE_CYC(50), .TEST_CYC(9000)) dut (.clock, .resetn,
    .field_in, .leg_rx, .leg_tx, .force_zero, .force_one);
  tdic_mp #(.NPTS(N), .BIT(`TDIC_BIT_CYC)) mp0 (.clock, .leg_tx(leg_tx[0]), .leg_rx(leg_rx[0]));
  tdic_mp #(.NPTS(N), .BIT(`TDIC_BIT_CYC)) mp1 (.clock, .leg_tx(leg_tx[1]), .leg_rx(leg_rx[1]));
  tdic_mp #(.NPTS(N), .BIT(`TDIC_BIT_CYC)) mp2 (.clock, .leg_tx(leg_tx[2]), .leg_rx(leg_rx[2]));
  // single variant, polled on leg 0 only; legs 1 and 2 stay idle
  tdic_top #(.NPTS(N), .SINGLE(1'b1), .SAMPLE_CYC(50), .TEST_CYC(9000)) dut_single (.clock,
    .resetn, .field_in(fs_in), .leg_rx({2'h3, rx_s}), .leg_tx(tx_s), .force_zero(fz_s),
    .force_one(fo_s));
  tdic_mp #(.NPTS(N), .BIT(`TDIC_BIT_CYC)) mp_s (.clock, .leg_tx(tx_s[0]), .leg_rx(rx_s));
  // closed test switch reads OFF except on points made stuck ON
  // forced-ON switch reads ON except on points made stuck OFF
  always @(posedge clock) begin
    for (int i = 0; i < 3; i++) begin
      field_in[i*N +: N] <= force_zero[i] ? stuck[i] : pat[i];
      fs_in[i*N +: N]    <= fo_s[i] ? ~soff[i] : (fz_s[i] ? 16'h0 : pat[i]);
    end
  end
  task automatic chk(input logic [N-1:0] got, input logic [N-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // processors vote the three copies two out of three
  function automatic logic [N-1:0] vote(input logic [N-1:0] a,
                                        input logic [N-1:0] b,
                                        input logic [N-1:0] c);
    vote = (a & b) | (a & c) | (b & c);
  endfunction
  task automatic wait_fz(input int c, input logic v);
    int n;
    n = 0;
    while (force_zero[c] !== v && n < 12000) begin
      @(negedge clock);
      n++;
    end
    chk({15'h0, force_zero[c]}, {15'h0, v});
  endtask
  task automatic t_tables;
    repeat (200) @(posedge clock);
    fork
      mp0.poll(d0, ok0);
      mp1.poll(d1, ok1);
      mp2.poll(d2, ok2);
    join
    chk(d0[N-1:0], 16'hA5C3);
    chk(d1[N-1:0], 16'h3C0F);
    chk(d2[N-1:0], 16'hF00F);
    chk(d1[2*N-1:N], 16'h0);
    chk({15'h0, ok0 & ok1 & ok2}, 16'h1);
    chk(vote(d0[N-1:0], d1[N-1:0], d2[N-1:0]), 16'hB40F);
  endtask
  task automatic t_freeze;
    wait_fz(0, 1'h1);
    // let sample ticks pass on the forced reading, so a table that did not freeze shows
    repeat (100) @(posedge clock);
    mp0.poll(d0, ok0);
    chk(d0[N-1:0], 16'hA5C3);
    chk(d0[2*N-1:N], 16'h0);
  endtask
  task automatic t_stuck;
    stuck[1] = 16'h0081;
    wait_fz(1, 1'h1);
    wait_fz(1, 1'h0);
    mp1.poll(d1, ok1);
    chk(d1[N-1:0], 16'h3C0E);
    chk(d1[2*N-1:N], 16'h0081);
    mp1.poll(d1, ok1);
    chk(d1[N-1:0], 16'h3C0E);
    chk(d1[2*N-1:N], 16'h0);
    stuck[1] = 16'h0;
    wait_fz(1, 1'h1);
    wait_fz(1, 1'h0);
    mp1.poll(d1, ok1);
    chk(d1[N-1:0], 16'h3C0F);
  endtask
  task automatic t_single;
    int n;
    n = 0;
    while (fo_s[0] !== 1'h1 && n < 12000) begin
      @(negedge clock);
      n++;
    end
    chk({15'h0, fo_s[0]}, 16'h1);
    while (fo_s[0] !== 1'h0 && n < 24000) begin
      @(negedge clock);
      n++;
    end
    chk({15'h0, fo_s[0]}, 16'h0);
    mp_s.poll(ds, oks);
    chk(ds[N-1:0], 16'hA4C3);
    chk(ds[2*N-1:N], 16'h0100);
    chk({15'h0, oks}, 16'h1);
  endtask
  initial begin
    clock = 1'h0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    resetn = 1'h0;
    bad_count = 0;
    num_checks = 0;
    pat = '{16'hA5C3, 16'h3C0F, 16'hF00F};
    stuck = '{default: 16'h0};
    soff = '{16'h0100, 16'h0, 16'h0};
    repeat (4) @(posedge clock);
    resetn <= 1'h1;
    t_tables;
    fork
      t_freeze;
      t_single;
    join
    t_stuck;
    summarize;
  end
  // the sequence needs about 31k cycles; allow twice that
  initial begin
    repeat (60000) @(posedge clock);
    bad_count++;
    summarize;
  end
endmodule
